// *** logic/bpp_pkg.sv ***
/*
 * Constants, register map and carrier types for the bidirectional port
 * with slave-port and PWM pin overrides.
 * Assumes an 8-bit register port with byte addresses and one system clock.
 */
package bpp_pkg;
    localparam int unsigned BPP_W = 8;
    localparam int unsigned BPP_AW = 8;

    // register byte addresses
    localparam logic [7:0] BPP_ADDR_LEVELS = 8'h00;
    localparam logic [7:0] BPP_ADDR_LATCH = 8'h04;
    localparam logic [7:0] BPP_ADDR_DIR = 8'h08;
    localparam logic [7:0] BPP_ADDR_SPCS = 8'h0c;
    localparam logic [7:0] BPP_ADDR_PWMCFG = 8'h10;
    localparam logic [7:0] BPP_ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] BPP_ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] BPP_ADDR_CTRL = 8'h1c;

    // reset values
    localparam logic [7:0] BPP_LATCH_RST = 8'h00;
    localparam logic [7:0] BPP_DIR_RST = 8'hff;
    localparam logic [2:0] BPP_REDIR_RST = 3'h7;
    localparam logic [7:0] BPP_PWMCFG_RST = 8'h00;
    localparam logic [2:0] BPP_IRQ_RST = 3'h0;

    // slave_port_control_status fields
    localparam int unsigned BPP_SPCS_IBF = 7;
    localparam int unsigned BPP_SPCS_OBF = 6;
    localparam int unsigned BPP_SPCS_OVF = 5;
    localparam int unsigned BPP_SPCS_MODE = 4;
    localparam int unsigned BPP_SPCS_UNUSED = 3;
    localparam int unsigned BPP_SPCS_REDIR_HI = 2;

    // pwm_capture_config fields
    localparam int unsigned BPP_PWM_CFG_HI = 7;
    localparam int unsigned BPP_PWM_CFG_LO = 6;
    localparam int unsigned BPP_PWM_MODE_HI = 3;
    localparam int unsigned BPP_PWM_MODE_LO = 2;
    localparam logic [1:0] BPP_PWM_MODE_PWM = 2'h3;
    localparam logic [1:0] BPP_PWM_CFG_SINGLE = 2'h0;

    // pin index carrying pwm channel b; c and d follow
    localparam int unsigned BPP_PIN_PWM_B = 5;

    // interrupt status / mask bits
    localparam int unsigned BPP_IRQ_W = 3;
    localparam int unsigned BPP_IRQ_RX = 0;
    localparam int unsigned BPP_IRQ_TX = 1;
    localparam int unsigned BPP_IRQ_OVF = 2;

    // control register bit: pwm pins float during shutdown
    localparam int unsigned BPP_CTRL_TRI = 0;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] dout;
    } bpp_pad_t;

    typedef struct packed {
        logic rd;
        logic wr;
    } bpp_host_t;
endpackage

// *** logic/bpp_sync8.sv ***
/*
 * Two-flop synchroniser for the eight pin inputs.
 * Assumes the shared system clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module bpp_sync8 (
    input wire logic i_ref_clk, // system clock
    input wire logic i_sys_rst, // synchronous reset
    input wire logic [7:0] i_d, // raw pin levels
    output logic [7:0] o_q // synchronised levels
);
    logic [7:0] meta_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            meta_q <= 8'h00;
            o_q <= 8'h00;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule // bpp_sync8
`default_nettype wire

// *** logic/bpp_port.sv ***
/*
 * Eight-pin bidirectional port with output latch, direction register,
 * parallel slave port data path and pwm channel b/c/d pin override.
 * Assumes synchronous host strobes, an external pwm generator and a
 * register master that never issues read and write together.
 */
`timescale 1ns/100ps
`default_nettype none
module bpp_port (
    input wire logic i_ref_clk, // system clock, 100 MHz
    input wire logic i_sys_rst, // synchronous reset, active high
    input wire logic [bpp_pkg::BPP_AW-1:0] i_addr, // register byte address
    input wire logic [bpp_pkg::BPP_W-1:0] i_wdata, // register write data
    input wire logic i_wr, // register write strobe
    input wire logic i_rd, // register read strobe
    output logic [bpp_pkg::BPP_W-1:0] o_rdata, // read data, cycle after strobe
    input wire logic [7:0] i_pin, // pin levels
    output bpp_pkg::bpp_pad_t o_pad, // pin drive value and enable
    input wire bpp_pkg::bpp_host_t i_host, // host read level, write pulse
    input wire logic [2:0] i_pwm_bcd, // pwm channels d, c, b
    input wire logic i_pwm_shutdown, // pwm shutdown event active
    output logic o_irq // level interrupt
);
    import bpp_pkg::*;

    function automatic logic flag_next(input logic q, input logic set, input logic clr);
        flag_next = set | (q & ~clr);
    endfunction

    logic [7:0] latch_q, dir_q, pwmcfg_q, in_word_q, sync_q, rdata_q;
    logic ibf_q, obf_q, ovf_q, mode_q, tri_q, rd_prev_q, irq_q;
    logic [2:0] redir_q;
    logic [BPP_IRQ_W-1:0] irq_stat_q, irq_mask_q;
    bpp_pad_t pad_q;

    bpp_sync8 u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_d(i_pin),
        .o_q(sync_q)
    );

    // address decode
    wire sel_levels = (i_addr == BPP_ADDR_LEVELS);
    wire sel_latch = (i_addr == BPP_ADDR_LATCH);
    wire sel_dir = (i_addr == BPP_ADDR_DIR);
    wire sel_spcs = (i_addr == BPP_ADDR_SPCS);
    wire sel_pwmcfg = (i_addr == BPP_ADDR_PWMCFG);
    wire sel_stat = (i_addr == BPP_ADDR_IRQ_STAT);
    wire sel_mask = (i_addr == BPP_ADDR_IRQ_MASK);
    wire sel_ctrl = (i_addr == BPP_ADDR_CTRL);

    wire wr_port = i_wr & (sel_levels | sel_latch);
    wire rd_levels = i_rd & sel_levels;

    // pwm configuration decode
    wire [1:0] pwm_cfg = pwmcfg_q[BPP_PWM_CFG_HI:BPP_PWM_CFG_LO];
    wire pwm_mode = (pwmcfg_q[BPP_PWM_MODE_HI:BPP_PWM_MODE_LO] == BPP_PWM_MODE_PWM);
    wire pwm_multi = pwm_mode & (pwm_cfg != BPP_PWM_CFG_SINGLE);
    wire pwm_quad = pwm_multi & pwmcfg_q[BPP_PWM_CFG_LO];
    wire [2:0] pwm_use = {pwm_quad, pwm_quad, pwm_multi};
    wire [2:0] pwm_on = pwm_use & ~dir_q[7:BPP_PIN_PWM_B];
    wire [7:0] pwm_on8 = {pwm_on, 5'h00};
    wire [7:0] pwm_val8 = {i_pwm_bcd, 5'h00};
    wire pwm_hiz = i_pwm_shutdown & tri_q;

    // slave port is off whenever pwm uses two or four outputs
    wire sp_active = mode_q & ~pwm_multi;

    // host events
    wire host_wr_ev = sp_active & i_host.wr;
    wire host_rd_rise = sp_active & i_host.rd & ~rd_prev_q;
    wire ovf_ev = host_wr_ev & ibf_q;

    // pin drive selection: pwm, then slave-port read, then port data
    wire [7:0] port_oe = sp_active ? {8{i_host.rd}} : ~dir_q;
    wire [7:0] oe_d = (pwm_on8 & {8{~pwm_hiz}}) | (~pwm_on8 & port_oe);
    wire [7:0] dout_d = (pwm_on8 & pwm_val8) | (~pwm_on8 & latch_q);

    // status flags, set wins over clear
    wire ibf_d = flag_next(ibf_q, host_wr_ev, rd_levels & sp_active);
    wire obf_d = flag_next(obf_q, wr_port & sp_active, host_rd_rise);
    wire ovf_hold = (i_wr & sel_spcs) ? i_wdata[BPP_SPCS_OVF] : ovf_q;
    wire ovf_d = ovf_ev | ovf_hold;

    wire [BPP_IRQ_W-1:0] irq_set = {ovf_ev, host_rd_rise, host_wr_ev};
    wire [BPP_IRQ_W-1:0] irq_clr = (i_wr & sel_stat) ? i_wdata[BPP_IRQ_W-1:0] : '0;
    wire [BPP_IRQ_W-1:0] irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);

    wire [7:0] spcs_rd = {ibf_q, obf_q, ovf_q, mode_q, 1'b0, redir_q};
    wire [7:0] levels_rd = sp_active ? in_word_q : sync_q;
    wire [7:0] rdata_d = !i_rd ? 8'h00 :
                         sel_levels ? levels_rd :
                         sel_latch ? latch_q :
                         sel_dir ? dir_q :
                         sel_spcs ? spcs_rd :
                         sel_pwmcfg ? pwmcfg_q :
                         sel_stat ? {5'h00, irq_stat_q} :
                         sel_mask ? {5'h00, irq_mask_q} :
                         sel_ctrl ? {7'h00, tri_q} : 8'h00;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            latch_q <= BPP_LATCH_RST;
            dir_q <= BPP_DIR_RST;
            redir_q <= BPP_REDIR_RST;
            mode_q <= 1'b0;
            pwmcfg_q <= BPP_PWMCFG_RST;
            tri_q <= 1'b0;
            irq_mask_q <= BPP_IRQ_RST;
        end else if (i_wr) begin
            if (wr_port) latch_q <= i_wdata;
            if (sel_dir) dir_q <= i_wdata;
            if (sel_spcs) begin
                mode_q <= i_wdata[BPP_SPCS_MODE];
                redir_q <= i_wdata[BPP_SPCS_REDIR_HI:0];
            end
            if (sel_pwmcfg) pwmcfg_q <= i_wdata;
            if (sel_ctrl) tri_q <= i_wdata[BPP_CTRL_TRI];
            if (sel_mask) irq_mask_q <= i_wdata[BPP_IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ibf_q <= 1'b0;
            obf_q <= 1'b0;
            ovf_q <= 1'b0;
            in_word_q <= 8'h00;
            rd_prev_q <= 1'b0;
            irq_stat_q <= BPP_IRQ_RST;
        end else begin
            ibf_q <= ibf_d;
            obf_q <= obf_d;
            ovf_q <= ovf_d;
            if (host_wr_ev) in_word_q <= i_pin;
            rd_prev_q <= i_host.rd;
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pad_q <= '0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            pad_q <= '{oe: oe_d, dout: dout_d};
            rdata_q <= rdata_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    assign o_pad = pad_q;
    assign o_rdata = rdata_q;
    assign o_irq = irq_q;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_latch_write;
        i_wr && sel_latch;
    endsequence

    sequence s_latch_read;
        i_rd && sel_latch;
    endsequence

    a_latch_readback: assert property (
        (s_latch_write ##1 s_latch_read) |=> (o_rdata == $past(i_wdata, 2)))
        else $error("latch read does not return the written value");

    a_input_hiz: assert property (
        (dir_q == 8'hff && !(sp_active && i_host.rd)) |=> (o_pad.oe == 8'h00))
        else $error("input pin is being driven");

    a_output_drive: assert property (
        (!sp_active && dir_q == 8'h00 && !pwm_multi)
        |=> (o_pad.oe == 8'hff && o_pad.dout == $past(latch_q)))
        else $error("output pin does not show the latch");

    a_reset_inputs: assert property (
        disable iff (1'b0) i_sys_rst |=> (o_pad.oe == 8'h00 && dir_q == 8'hff))
        else $error("pins not inputs after reset");

    a_sp_read_drive: assert property (
        (sp_active && i_host.rd && pwm_on == 3'h0)
        |=> (o_pad.oe == 8'hff && o_pad.dout == $past(latch_q)))
        else $error("slave read does not drive the latch");

    a_sp_write_cap: assert property (
        (sp_active && i_host.wr) |=> (in_word_q == $past(i_pin) && ibf_q))
        else $error("slave write not captured");

    a_pwm_blocks_sp: assert property (
        (pwm_multi && i_host.wr) |=> ($stable(ibf_q) && $stable(in_word_q)))
        else $error("host write taken during multi-output pwm");

    a_pwm_override: assert property (
        (pwm_on[0] && !pwm_hiz)
        |=> (o_pad.oe[BPP_PIN_PWM_B] && o_pad.dout[BPP_PIN_PWM_B] == $past(i_pwm_bcd[0])))
        else $error("pwm channel b not on its pin");

    a_shutdown_hiz: assert property (
        (pwm_on[0] && pwm_hiz) |=> !o_pad.oe[BPP_PIN_PWM_B])
        else $error("pwm pin driven during shutdown float");

    a_unused_zero: assert property (
        (i_rd && sel_spcs) |=> (o_rdata[BPP_SPCS_UNUSED] == 1'b0 && o_rdata[7] == $past(ibf_q)))
        else $error("slave control read wrong");

    a_overflow_set: assert property (
        (sp_active && i_host.wr && ibf_q) |=> (ovf_q && irq_stat_q[BPP_IRQ_OVF]) [*1])
        else $error("overflow not flagged");

    a_output_full: assert property (
        (wr_port && sp_active) |=> obf_q)
        else $error("output-full not set on write");

    a_levels_read: assert property (
        (i_rd && sel_levels && !sp_active) |=> (o_rdata == $past(sync_q)))
        else $error("pin level read wrong");

    a_irq_level: assert property (
        1'b1 |=> (o_irq == |(irq_stat_q & $past(irq_mask_q))))
        else $error("interrupt output mismatch");

    // flag, register port and pin override checks
    sequence s_host_read_idle;
        !i_host.rd;
    endsequence

    sequence s_host_read_start;
        sp_active && i_host.rd && !(wr_port && sp_active);
    endsequence

    a_obf_clear: assert property (
        (s_host_read_idle ##1 s_host_read_start) |=> !obf_q)
        else $error("output-full not cleared by the host read");

    a_ibf_clear: assert property (
        (rd_levels && sp_active && !host_wr_ev) |=> !ibf_q)
        else $error("input-full not cleared by the port read");

    a_ovf_sticky: assert property (
        (ovf_q && !(i_wr && sel_spcs)) |=> ovf_q)
        else $error("overflow flag dropped without a software write");

    a_ovf_clear: assert property (
        (i_wr && sel_spcs && !i_wdata[BPP_SPCS_OVF] && !ovf_ev) |=> !ovf_q)
        else $error("overflow flag not cleared by software");

    a_stat_clear: assert property (
        (i_wr && sel_stat && !host_wr_ev && !host_rd_rise)
        |=> ((irq_stat_q & $past(i_wdata[BPP_IRQ_W-1:0])) == 3'h0))
        else $error("status bit not cleared by writing one");

    a_dir_write: assert property (
        (i_wr && sel_dir) |=> (dir_q == $past(i_wdata)))
        else $error("direction register not written");

    a_reset_quiet: assert property (
        disable iff (1'b0) i_sys_rst |=> (o_rdata == 8'h00 && !o_irq && !mode_q))
        else $error("outputs not quiet after reset");

    a_rdata_idle: assert property (
        !i_rd |=> (o_rdata == 8'h00))
        else $error("read data not zero outside a read");

    a_pwm_dual_pins: assert property (
        (pwm_multi && !pwm_quad && dir_q[7:6] == 2'b00)
        |=> (o_pad.dout[7:6] == $past(latch_q[7:6])))
        else $error("dual pwm took over pins six and seven");

    a_pwm_quad_pins: assert property (
        (pwm_quad && dir_q[7:6] == 2'b00 && !pwm_hiz)
        |=> (o_pad.oe[7:6] == 2'b11 && o_pad.dout[7:6] == $past(i_pwm_bcd[2:1])))
        else $error("quad pwm channels c and d not on their pins");

    a_sp_idle_float: assert property (
        (sp_active && !i_host.rd && pwm_on == 3'h0) |=> (o_pad.oe == 8'h00))
        else $error("slave port drives pins without a host read");

    a_levels_sp_read: assert property (
        (i_rd && sel_levels && sp_active) |=> (o_rdata == $past(in_word_q)))
        else $error("port read does not return the host word");

    a_shutdown_drive: assert property (
        (pwm_on[0] && i_pwm_shutdown && !tri_q) |=> o_pad.oe[BPP_PIN_PWM_B])
        else $error("pwm pin floated although float is off");
endmodule // bpp_port
`default_nettype wire

// *** tb/bpp_host_model.sv ***
/* external processor and board logic on the eight port pins.
   assumes bpp_port pads and the shared system clock. */
`timescale 1ns/100ps
`default_nettype none
module bpp_host_model (
    input wire logic i_ref_clk, // system clock
    input wire bpp_pkg::bpp_pad_t i_pad, // design pin drive
    output logic [7:0] o_pin, // resolved pin levels
    output var bpp_pkg::bpp_host_t o_host // host strobes
);
    import bpp_pkg::*;
    logic [7:0] board_q = 8'h00;
    logic [7:0] bus_q = 8'h00;
    logic drv_q = 1'b0;
    // host data wins while writing, then pads, then board
    assign o_pin = drv_q ? bus_q : ((i_pad.oe & i_pad.dout) | (~i_pad.oe & board_q));
    initial o_host = '0;
    task automatic host_write(input logic [7:0] d);
        @(posedge i_ref_clk);
        bus_q <= d;
        drv_q <= 1'b1;
        o_host.wr <= 1'b1;
        @(posedge i_ref_clk);
        o_host.wr <= 1'b0;
        drv_q <= 1'b0;
        bus_q <= ~d;
    endtask
    task automatic set_rd(input logic v);
        @(posedge i_ref_clk);
        o_host.rd <= v;
    endtask
endmodule // bpp_host_model
`default_nettype wire

// *** tb/bidir_port_with_psp_pwm_mux_bench.sv ***
/* register-level tests of bpp_port with a host and board model.
   assumes bpp_pkg map and the hand-over timing. */
`timescale 1ns/100ps
`default_nettype none
module bidir_port_with_psp_pwm_mux_bench;
    import bpp_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_s;
    logic rd_s;
    logic [2:0] pwm;
    logic shut;
    logic [7:0] o_rdata;
    logic [7:0] pin;
    bpp_pad_t o_pad;
    bpp_host_t host;
    logic o_irq;
    int fail_count = 0;
    int checked = 0;
    bpp_port i_bpp_port (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(o_rdata), .i_pin(pin),
        .o_pad(o_pad), .i_host(host), .i_pwm_bcd(pwm), .i_pwm_shutdown(shut), .o_irq(o_irq));
    bpp_host_model i_bpp_host_model (.i_ref_clk(i_ref_clk), .i_pad(o_pad), .o_pin(pin),
        .o_host(host));
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge i_ref_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge i_ref_clk);
        rd_s <= 1'b0;
        #1 chk({8'h00, o_rdata}, {8'h00, exp});
    endtask
    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge i_ref_clk);
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        @(posedge i_ref_clk);
        rd_s <= 1'b0;
        #1 chk({8'h00, o_rdata}, {8'h00, d});
    endtask
    // driven pads only: dout of floating pins is undefined
    task automatic pad(input logic [15:0] exp);
        repeat (2) @(posedge i_ref_clk);
        #1 chk({o_pad.oe, o_pad.dout & o_pad.oe}, exp);
    endtask
    task automatic irq(input logic exp);
        repeat (2) @(posedge i_ref_clk);
        #1 chk({15'h0, o_irq}, {15'h0, exp});
    endtask
    localparam logic [7:0] CFG [5] = '{8'h40, 8'h0c, 8'h4c, 8'h8c, 8'hcc};
    localparam logic [15:0] PADX [5] = '{16'h0000, 16'h0000, 16'hffa0, 16'hff20, 16'hffa0};
    initial begin
        addr <= 8'h00;
        wdata <= 8'h00;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        pwm <= 3'h0;
        shut <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        #1 chk(o_pad, 16'h0000);
        rd(BPP_ADDR_DIR, 8'hff);
        rd(BPP_ADDR_LATCH, 8'h00);
        rd(BPP_ADDR_SPCS, 8'h07);
        rd(BPP_ADDR_PWMCFG, 8'h00);
        rd(8'h20, 8'h00);
        wr(BPP_ADDR_LATCH, 8'ha5);
        wr(BPP_ADDR_DIR, 8'hf0);
        pad(16'h0f05);
        wr(BPP_ADDR_DIR, 8'hff);
        i_bpp_host_model.board_q <= 8'h3c;
        repeat (3) @(posedge i_ref_clk);
        rd(BPP_ADDR_LEVELS, 8'h3c);
        rd(BPP_ADDR_LATCH, 8'ha5);
        wr(BPP_ADDR_LEVELS, 8'h66);
        rd(BPP_ADDR_LATCH, 8'h66);
        wr_rd(BPP_ADDR_LATCH, 8'h5c);
        i_bpp_host_model.host_write(8'h11);
        rd(BPP_ADDR_SPCS, 8'h07);
        wr(BPP_ADDR_DIR, 8'h00);
        wr(BPP_ADDR_SPCS, 8'h17);
        rd(BPP_ADDR_SPCS, 8'h17);
        i_bpp_host_model.host_write(8'h5a);
        rd(BPP_ADDR_SPCS, 8'h97);
        irq(1'b0);
        wr(BPP_ADDR_IRQ_MASK, 8'h07);
        irq(1'b1);
        i_bpp_host_model.host_write(8'h5a);
        rd(BPP_ADDR_SPCS, 8'hb7);
        rd(BPP_ADDR_LEVELS, 8'h5a);
        rd(BPP_ADDR_SPCS, 8'h37);
        wr(BPP_ADDR_SPCS, 8'h17);
        rd(BPP_ADDR_SPCS, 8'h17);
        wr(BPP_ADDR_DIR, 8'hff);
        wr(BPP_ADDR_LATCH, 8'h3c);
        rd(BPP_ADDR_SPCS, 8'h57);
        i_bpp_host_model.set_rd(1'b1);
        pad(16'hff3c);
        i_bpp_host_model.set_rd(1'b0);
        rd(BPP_ADDR_SPCS, 8'h17);
        rd(BPP_ADDR_IRQ_STAT, 8'h07);
        wr(BPP_ADDR_IRQ_STAT, 8'h07);
        rd(BPP_ADDR_IRQ_STAT, 8'h00);
        irq(1'b0);
        wr(BPP_ADDR_DIR, 8'h00);
        wr(BPP_ADDR_LATCH, 8'h00);
        pwm <= 3'h5;
        for (int i = 0; i < 5; i++) begin
            wr(BPP_ADDR_PWMCFG, CFG[i]);
            pad(PADX[i]);
        end
        i_bpp_host_model.host_write(8'haa);
        rd(BPP_ADDR_SPCS, 8'h57);
        shut <= 1'b1;
        pad(16'hffa0);
        wr(BPP_ADDR_CTRL, 8'h01);
        pad(16'h1f00);
        report_and_stop();
    end
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule // bidir_port_with_psp_pwm_mux_bench
`default_nettype wire
